// *** inc/aac_consts.svh ***
// Timing figures, instruction codes and response codes of the alert command interpreter
`ifndef AAC_CONSTS_SVH
`define AAC_CONSTS_SVH

`define AAC_CLK_HZ        40000000
`define AAC_BAUD_BPS      9600
`define AAC_BIT_CYC       (`AAC_CLK_HZ / `AAC_BAUD_BPS)
`define AAC_SILENCE_MS    2000
`define AAC_SILENCE_CYC   (`AAC_SILENCE_MS * (`AAC_CLK_HZ / 1000))
`define AAC_HOLD_MS       2000
`define AAC_HOLD_CYC      (`AAC_HOLD_MS * (`AAC_CLK_HZ / 1000))
`define AAC_WAIT_MS       50
`define AAC_WAIT_CYC      (`AAC_WAIT_MS * (`AAC_CLK_HZ / 1000))
`define AAC_BLINK_MS      250
`define AAC_BLINK_CYC     (`AAC_BLINK_MS * (`AAC_CLK_HZ / 1000))

`define AAC_OP_STOP       8'h1f
`define AAC_OP_PASS_ON    8'h20
`define AAC_OP_PASS_OFF   8'h00
`define AAC_OP_ONE_CELL   8'h03
`define AAC_OP_STATUS     8'h40
`define AAC_TOP_REPEAT    2'h0
`define AAC_TOP_PLAY      2'h1
`define AAC_TOP_RECORD    2'h2
`define AAC_TOP_SPEAKER   2'h3
`define AAC_TOP_CONFIG    3'h0

`define AAC_RSP_REC_DONE  8'h7e
`define AAC_RSP_PLAY_GO   8'h40
`define AAC_RSP_MISMATCH  8'h7f
`define AAC_RSP_TIMEOUT   8'h40

`define AAC_MAX_CELL      6'h3c
`define AAC_DEF_CELLS     8'h08
`define AAC_ONE_CELLS     8'h01
`define AAC_MAN_CELLS     4'h8
`define AAC_LED_ALL       4'hf
`define AAC_UART_BITS     4'ha
`define AAC_TXQ_DEPTH     4'h8

`endif

// *** inc/aac_pkg.sv ***
// Types of the alert command interpreter
package aac_pkg;

  typedef enum logic [3:0] {
    AAC_RX_IDLE  = 4'h1,
    AAC_RX_START = 4'h2,
    AAC_RX_DATA  = 4'h4,
    AAC_RX_STOP  = 4'h8
  } aac_rx_e;

  typedef enum logic [1:0] {
    AAC_CMD_FIRST  = 2'h1,
    AAC_CMD_SECOND = 2'h2
  } aac_cmd_e;

  typedef logic [26:0] aac_cnt_t;

  typedef struct packed {
    logic                rx_s1, rx_s2, dtr_s1, dtr_s2, pb_s1, pb_s2, aud_s1, aud_s2;
    aac_rx_e             rx_st;
    aac_cnt_t            rx_cnt;
    logic [2:0]          rx_bit;
    logic [7:0]          rx_sh;
    logic                rx_valid;
    logic [7:0]          rx_byte;
    aac_cmd_e            cmd;
    logic [7:0]          first;
    aac_cnt_t            win_cnt;
    logic [7:0][7:0]     tx_q;
    logic [3:0]          tx_n;
    logic [9:0]          tx_sh;
    logic [3:0]          tx_bits;
    aac_cnt_t            tx_cnt;
    logic                txd;
    logic                printer_txd;
    logic [5:0]          spk;
    logic                pass;
    logic                playing;
    logic [5:0]          play_cell;
    logic [4:0]          rep;
    logic                play_start;
    logic                rec;
    logic [5:0]          rec_cell;
    logic                rec_start;
    aac_cnt_t            sil_cnt;
    logic [7:0]          cells;
    aac_cnt_t            pb_cnt;
    logic                pb_prev;
    logic                manual;
    logic [3:0]          sel;
    aac_cnt_t            blink_cnt;
    logic [3:0]          leds;
  } aac_state_s;

endpackage

// *** hw/aac_top.sv ***
// Alert unit command interpreter: serial receive, double-copy check, execution, replies, manual record
`timescale 1ns/1ps
`include "aac_consts.svh"

// Summary of operation
// - Link runs 9600 bps, one stop, no parity
// - Mismatched second copy discards the instruction
// - Accepted instruction is echoed back as acknowledgement
// - During playback a single copy is executed
// - Code 01 plays cell 1-60, drops pass-through
// - Code 10 records into cell 1-60
// - Code 11 sets six speaker relays
// - Repeat count 1-31 only while playing
// - Stop code halts current playback
// - Enable code routes audio input to output
// - Disable code mutes output and stops playback
// - Configure code sets cells to twice field
// - Single-cell code sets one cell
// - Status request returns four bytes, echo first
// - Status bytes carry relays, flags, cells, cell
// - Finished recording sends record-completed code
// - Playback start sends play-started code
// - Idle mismatch sends inconsistency code
// - Idle single copy sends time-out code
// - Long button hold enters manual mode; presses step
// - Manual mode records on audio, LEDs blink
// - Terminal ready selects decoder, else printer port
// - Recording ends after silence or full cell
// - Eight cells after reset
module aac_top #(
  parameter int BIT_CYC   = `AAC_BIT_CYC,
  parameter int SIL_CYC   = `AAC_SILENCE_CYC,
  parameter int HOLD_CYC  = `AAC_HOLD_CYC,
  parameter int WAIT_CYC  = `AAC_WAIT_CYC,
  parameter int BLINK_CYC = `AAC_BLINK_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       host_rxd,
  input  wire logic       host_dtr,
  output logic            host_txd,
  output logic            printer_txd,
  input  wire logic       manual_record_button,
  input  wire logic       audio_detect,
  input  wire logic       cell_full,
  input  wire logic       play_done,
  output logic [5:0]      speaker_on,
  output logic            pass_through,
  output logic            play_active,
  output logic            play_start,
  output logic [5:0]      play_cell,
  output logic            rec_active,
  output logic            rec_start,
  output logic [5:0]      rec_cell,
  output logic [7:0]      cell_count,
  output logic [3:0]      leds
);
  import aac_pkg::*;

  aac_state_s      q;
  aac_state_s      d;
  logic            ex_go;
  logic [7:0]      ex_b;
  logic [4:0][7:0] lb;
  logic [2:0]      lc;
  logic [3:0]      pn;
  logic            cell_ok;

  // Replies are queued so a status burst is kept behind an acknowledgement while the eight-entry queue has room
  always_comb begin
    d       = q;
    ex_go   = 1'b0;
    ex_b    = q.rx_byte;
    lb      = '0;
    lc      = 3'h0;
    pn      = 4'h0;
    cell_ok = 1'b0;
    d.rx_s1  = host_rxd;
    d.rx_s2  = q.rx_s1;
    d.dtr_s1 = host_dtr;
    d.dtr_s2 = q.dtr_s1;
    d.pb_s1  = manual_record_button;
    d.pb_s2  = q.pb_s1;
    d.aud_s1 = audio_detect;
    d.aud_s2 = q.aud_s1;
    d.rx_valid   = 1'b0;
    d.play_start = 1'b0;
    d.rec_start  = 1'b0;
    d.printer_txd = q.dtr_s2 ? 1'b1 : q.rx_s2;

    d.rx_cnt = q.rx_cnt + 27'h1;
    unique case (q.rx_st)
      AAC_RX_IDLE: begin
        d.rx_cnt = '0;
        if (!q.rx_s2) begin
          d.rx_st = AAC_RX_START;
        end
      end
      AAC_RX_START: begin
        if (q.rx_cnt == 27'(BIT_CYC / 2)) begin
          d.rx_cnt = '0;
          d.rx_bit = 3'h0;
          d.rx_st  = q.rx_s2 ? AAC_RX_IDLE : AAC_RX_DATA;
        end
      end
      AAC_RX_DATA: begin
        if (q.rx_cnt == 27'(BIT_CYC - 1)) begin
          d.rx_cnt = '0;
          d.rx_sh  = {q.rx_s2, q.rx_sh[7:1]};
          d.rx_bit = q.rx_bit + 3'h1;
          if (q.rx_bit == 3'h7) begin
            d.rx_st = AAC_RX_STOP;
          end
        end
      end
      AAC_RX_STOP: begin
        if (q.rx_cnt == 27'(BIT_CYC - 1)) begin
          d.rx_st = AAC_RX_IDLE;
          if (q.rx_s2 && q.dtr_s2) begin
            d.rx_valid = 1'b1;
            d.rx_byte  = q.rx_sh;
          end
        end
      end
    endcase

    unique case (q.cmd)
      AAC_CMD_FIRST: begin
        d.win_cnt = '0;
        if (q.rx_valid) begin
          if (q.playing) begin
            ex_go = 1'b1;
          end else begin
            d.first = q.rx_byte;
            d.cmd   = AAC_CMD_SECOND;
          end
        end
      end
      AAC_CMD_SECOND: begin
        d.win_cnt = q.win_cnt + 27'h1;
        if (q.rx_valid) begin
          d.cmd = AAC_CMD_FIRST;
          if (q.rx_byte == q.first) begin
            ex_go = 1'b1;
          end else begin
            lb[0] = `AAC_RSP_MISMATCH;
            lc    = 3'h1;
          end
        end else if (q.win_cnt == 27'(WAIT_CYC - 1)) begin
          d.cmd = AAC_CMD_FIRST;
          lb[0] = `AAC_RSP_TIMEOUT;
          lc    = 3'h1;
        end
      end
    endcase

    cell_ok = (ex_b[5:0] != 6'h0) && (ex_b[5:0] <= `AAC_MAX_CELL) && ({2'h0, ex_b[5:0]} <= q.cells);
    if (ex_go) begin
      lb[0] = ex_b;
      lc    = 3'h1;
      if (ex_b == `AAC_OP_STOP) begin
        d.playing = 1'b0;
        d.rep     = 5'h0;
      end else if (ex_b == `AAC_OP_PASS_ON) begin
        d.pass = 1'b1;
      end else if (ex_b == `AAC_OP_PASS_OFF) begin
        d.pass    = 1'b0;
        d.playing = 1'b0;
        d.rep     = 5'h0;
      end else if (ex_b[7:6] == `AAC_TOP_REPEAT && q.playing) begin
        if (ex_b[4:0] != 5'h0) begin
          d.rep = ex_b[4:0];
        end else begin
          lc = 3'h0;
        end
      end else if (ex_b == `AAC_OP_ONE_CELL) begin
        d.cells = `AAC_ONE_CELLS;
      end else if (ex_b[7:5] == `AAC_TOP_CONFIG) begin
        if (ex_b[4:0] != 5'h0) begin
          d.cells = {2'h0, ex_b[4:0], 1'b0};
        end else begin
          lc = 3'h0;
        end
      end else if (ex_b == `AAC_OP_STATUS) begin
        lb[1] = {q.pass, q.playing, q.spk};
        lb[2] = q.cells;
        lb[3] = q.playing ? {2'h0, q.play_cell} : 8'h00;
        lc    = 3'h4;
      end else if (ex_b[7:6] == `AAC_TOP_PLAY) begin
        if (cell_ok) begin
          d.playing    = 1'b1;
          d.pass       = 1'b0;
          d.play_cell  = ex_b[5:0];
          d.rep        = 5'h0;
          d.play_start = 1'b1;
          lb[1] = `AAC_RSP_PLAY_GO;
          lc    = 3'h2;
        end else begin
          lc = 3'h0;
        end
      end else if (ex_b[7:6] == `AAC_TOP_RECORD) begin
        if (cell_ok && !q.rec) begin
          d.rec       = 1'b1;
          d.rec_cell  = ex_b[5:0];
          d.rec_start = 1'b1;
          d.sil_cnt   = '0;
        end else begin
          lc = 3'h0;
        end
      end else if (ex_b[7:6] == `AAC_TOP_SPEAKER) begin
        d.spk = ex_b[5:0];
      end else begin
        lc = 3'h0;
      end
    end

    if (q.playing && play_done && d.playing) begin
      if (q.rep != 5'h0) begin
        d.rep        = q.rep - 5'h1;
        d.play_start = 1'b1;
      end else begin
        d.playing = 1'b0;
      end
    end

    if (q.rec) begin
      d.sil_cnt = q.aud_s2 ? '0 : q.sil_cnt + 27'h1;
      // silence or full cell ends recording
      if (cell_full || (!q.aud_s2 && q.sil_cnt == 27'(SIL_CYC - 1))) begin
        d.rec = 1'b0;
        lb[lc] = `AAC_RSP_REC_DONE;
        lc     = lc + 3'h1;
        d.leds = q.manual ? q.sel : 4'h0;
      end else if (q.manual) begin
        d.blink_cnt = q.blink_cnt + 27'h1;
        if (q.blink_cnt == 27'(BLINK_CYC - 1)) begin
          d.blink_cnt = '0;
          d.leds      = (q.leds == 4'h0) ? q.sel : 4'h0;
        end
      end
    end

    // long hold toggles manual mode, short press steps cell
    d.pb_prev = q.pb_s2;
    if (q.pb_s2 && q.pb_cnt <= 27'(HOLD_CYC)) begin
      d.pb_cnt = q.pb_cnt + 27'h1;
    end
    if (q.pb_prev && !q.pb_s2) begin
      d.pb_cnt = '0;
      if (q.pb_cnt > 27'(HOLD_CYC)) begin
        d.manual = !q.manual;
        d.sel    = 4'h0;
        d.leds   = q.manual ? 4'h0 : `AAC_LED_ALL;
      end else if (q.manual && !q.rec) begin
        d.sel  = (q.sel == `AAC_MAN_CELLS) ? 4'h1 : q.sel + 4'h1;
        d.leds = d.sel;
      end
    end
    if (q.manual && q.sel != 4'h0 && !q.rec && !d.rec && q.aud_s2) begin
      d.rec       = 1'b1;
      d.rec_cell  = {2'h0, q.sel};
      d.rec_start = 1'b1;
      d.sil_cnt   = '0;
      d.blink_cnt = '0;
    end

    if (q.tx_bits == 4'h0 && q.tx_n != 4'h0) begin
      d.tx_sh   = {1'b1, q.tx_q[0], 1'b0};
      d.tx_bits = `AAC_UART_BITS;
      d.tx_cnt  = '0;
      for (int i = 0; i < 7; i++) begin
        d.tx_q[i] = q.tx_q[i + 1];
      end
      d.tx_n = q.tx_n - 4'h1;
    end else if (q.tx_bits != 4'h0) begin
      d.tx_cnt = q.tx_cnt + 27'h1;
      if (q.tx_cnt == 27'(BIT_CYC - 1)) begin
        d.tx_cnt  = '0;
        d.tx_sh   = {1'b1, q.tx_sh[9:1]};
        d.tx_bits = q.tx_bits - 4'h1;
      end
    end
    // Queue full drops further replies rather than stalling the decoder
    pn = d.tx_n;
    for (int i = 0; i < 5; i++) begin
      if (3'(i) < lc && pn < `AAC_TXQ_DEPTH) begin
        d.tx_q[pn[2:0]] = lb[i];
        pn              = pn + 4'h1;
      end
    end
    d.tx_n = pn;
    d.txd  = (d.tx_bits != 4'h0) ? d.tx_sh[0] : 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q         <= '0;
      q.rx_s1   <= 1'b1;
      q.rx_s2   <= 1'b1;
      q.rx_st   <= AAC_RX_IDLE;
      q.cmd     <= AAC_CMD_FIRST;
      q.txd     <= 1'b1;
      q.printer_txd <= 1'b1;
      q.cells   <= `AAC_DEF_CELLS;
    end else begin
      q <= d;
    end
  end

  assign host_txd     = q.txd;
  assign printer_txd  = q.printer_txd;
  assign speaker_on   = q.spk;
  assign pass_through = q.pass;
  assign play_active  = q.playing;
  assign play_start   = q.play_start;
  assign play_cell    = q.play_cell;
  assign rec_active   = q.rec;
  assign rec_start    = q.rec_start;
  assign rec_cell     = q.rec_cell;
  assign cell_count   = q.cells;
  assign leds         = q.leds;

  sequence s_play_req;
    ex_go && ex_b[7:6] == 2'h1 && cell_ok;
  endsequence
  sequence s_play_go;
    play_start && play_active && !pass_through;
  endsequence

  AST_PLAY: assert property (@(posedge clk) disable iff (!arst_n) s_play_req |=> s_play_go)
    else $error("play instruction did not start playback");
  AST_MISMATCH: assert property (@(posedge clk) disable iff (!arst_n)
    q.cmd == AAC_CMD_SECOND && q.rx_valid && q.rx_byte != q.first |-> !ex_go)
    else $error("mismatched copy was executed");
  AST_TIMEOUT: assert property (@(posedge clk) disable iff (!arst_n)
    q.cmd == AAC_CMD_SECOND && !q.rx_valid && q.win_cnt == 27'(WAIT_CYC - 1) |=> q.cmd == AAC_CMD_FIRST && q.tx_n != 4'h0)
    else $error("window expiry gave no time-out reply");
  AST_SPK: assert property (@(posedge clk) disable iff (!arst_n)
    ex_go && ex_b[7:6] == 2'h3 |=> speaker_on == $past(ex_b[5:0]))
    else $error("speaker relays not taken from instruction");
  AST_STOP: assert property (@(posedge clk) disable iff (!arst_n)
    ex_go && (ex_b == `AAC_OP_STOP || ex_b == `AAC_OP_PASS_OFF) |=> !play_active)
    else $error("stop did not halt playback");
  AST_PASS: assert property (@(posedge clk) disable iff (!arst_n)
    ex_go && ex_b == `AAC_OP_PASS_ON |=> pass_through [*2])
    else $error("pass-through not enabled");
  AST_CFG: assert property (@(posedge clk) disable iff (!arst_n)
    ex_go && ex_b[7:5] == 3'h0 && ex_b != `AAC_OP_ONE_CELL && ex_b[4:0] != 5'h0 && ex_b != `AAC_OP_STOP && !play_active
    |=> cell_count == {2'h0, $past(ex_b[4:0]), 1'b0})
    else $error("cell count not twice the field");
  AST_RECEND: assert property (@(posedge clk) disable iff (!arst_n)
    rec_active && cell_full |=> !rec_active ##1 q.tx_n != 4'h0 || q.tx_bits != 4'h0)
    else $error("full cell did not end recording");
  AST_TXIDLE: assert property (@(posedge clk) disable iff (!arst_n)
    q.tx_bits != 4'h0 && q.tx_cnt != 27'(BIT_CYC - 1) |=> $stable(host_txd))
    else $error("serial output changed inside a bit period");
  AST_ECHO: assert property (@(posedge clk) disable iff (!arst_n)
    ex_go && ex_b[7:6] == 2'h3 && q.tx_n == 4'h0 && q.tx_bits == 4'h0 |=> q.tx_q[0] == $past(ex_b))
    else $error("accepted instruction not echoed");
endmodule

// *** dv/aac_host_model.sv ***
// Remote terminal controller model: sends framed bytes, collects reply frames
`timescale 1ns/1ps
module aac_host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk,
  input  wire logic host_txd,
  output logic      host_rxd
);
  logic [7:0] got_q[$];
  logic [7:0] rx_b;

  initial host_rxd = 1'b1;

  // one start, eight data LSB first, one stop
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      host_rxd <= fr[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask

  // mid-bit sampling; a frame with a low stop bit is dropped
  initial forever begin
    @(negedge host_txd);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      rx_b[i] = host_txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    if (host_txd === 1'b1) got_q.push_back(rx_b);
  end
endmodule

// *** dv/aac_top_bench.sv ***
// Self-checking bench for the alert command interpreter
`timescale 1ns/1ps
`include "aac_consts.svh"
module aac_top_bench;
  localparam int BIT_CYC = 16;
  localparam int SIL_CYC = 64;
  logic       clk, arst_n, host_dtr, button, audio_detect, cell_full, play_done;
  logic       host_rxd, host_txd, printer_txd, pass_through, play_active, play_start, rec_active;
  logic [5:0] speaker_on, play_cell, rec_cell, spk;
  logic [7:0] cell_count, b;
  logic [3:0] leds;
  logic [15:0] lfsr_q;
  logic [9:0] fr;
  logic [7:0] cfg_op[5] = '{8'h08, 8'h03, 8'h01, 8'h1e, 8'h04};
  logic [7:0] stop_op[2] = '{8'h1f, 8'h00};
  int         n_fail, compares, s0, r;
  int         n_starts = 0;
  int         n_rec = 0;
  logic       rec_start;
  bit         seen0, seen_sel;

  aac_top #(.BIT_CYC(BIT_CYC), .SIL_CYC(SIL_CYC), .HOLD_CYC(32), .WAIT_CYC(400), .BLINK_CYC(8)) u_dut (
    .clk(clk), .arst_n(arst_n), .host_rxd(host_rxd), .host_dtr(host_dtr), .host_txd(host_txd),
    .printer_txd(printer_txd), .manual_record_button(button), .audio_detect(audio_detect),
    .cell_full(cell_full), .play_done(play_done), .speaker_on(speaker_on), .pass_through(pass_through),
    .play_active(play_active), .play_start(play_start), .play_cell(play_cell), .rec_active(rec_active),
    .rec_start(rec_start), .rec_cell(rec_cell), .cell_count(cell_count), .leds(leds));

  aac_host_model #(.BIT_CYC(BIT_CYC)) u_host (.clk(clk), .host_txd(host_txd), .host_rxd(host_rxd));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Cell count that a configure code should leave behind
  function automatic logic [7:0] cells_of(input logic [7:0] op);
    return (op == 8'h03) ? 8'h01 : {op[6:0], 1'b0};
  endfunction

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // Bounded wait: a lost reply ends the run instead of hanging it
  task automatic expect_rsp(input logic [7:0] exp);
    int i;
    i = 0;
    while (u_host.got_q.size() == 0 && i < 3000) begin
      @(posedge clk);
      i++;
    end
    if (u_host.got_q.size() == 0) begin
      $display("[ERR] reply expected %h seen none", exp);
      n_fail++;
      test_done();
    end else chk("reply", exp, u_host.got_q.pop_front());
  endtask

  task automatic cmd2(input logic [7:0] c);
    u_host.send(c);
    u_host.send(c);
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
    chk("reply count", 8'h00, 8'(u_host.got_q.size()));
  endtask

  task automatic pdone();
    @(posedge clk);
    play_done <= 1'b1;
    @(posedge clk);
    play_done <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  always @(posedge clk) if (play_start === 1'b1) n_starts <= n_starts + 1;
  always @(posedge clk) if (rec_start === 1'b1) n_rec <= n_rec + 1;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    $display("[ERR] run length expected below limit seen limit");
    n_fail++;
    test_done();
  end

  initial begin
    arst_n = 1'b0; host_dtr = 1'b1; button = 1'b0; audio_detect = 1'b0; cell_full = 1'b0; play_done = 1'b0;
    n_fail = 0; compares = 0; lfsr_q = 16'h67d6;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("cell_count", 8'h08, cell_count);
    for (int k = 0; k < 3; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      spk = (k == 0) ? 6'h3f : lfsr_q[5:0];
      cmd2({2'h3, spk});
      expect_rsp({2'h3, spk});
      chk("speaker_on", 8'(spk), 8'(speaker_on));
    end
    u_host.send({2'h3, ~spk});
    u_host.send({2'h3, spk ^ 6'h01});
    expect_rsp(`AAC_RSP_MISMATCH);
    u_host.send({2'h3, ~spk});
    expect_rsp(`AAC_RSP_TIMEOUT);
    chk("speaker_on", 8'(spk), 8'(speaker_on));
    foreach (cfg_op[i]) begin
      cmd2(cfg_op[i]);
      expect_rsp(cfg_op[i]);
      chk("cell_count", cells_of(cfg_op[i]), cell_count);
    end
    cmd2(`AAC_OP_PASS_ON);
    expect_rsp(`AAC_OP_PASS_ON);
    chk("pass_through", 8'h01, 8'(pass_through));
    cmd2(`AAC_OP_PASS_OFF);
    expect_rsp(`AAC_OP_PASS_OFF);
    chk("pass_through", 8'h00, 8'(pass_through));
    cmd2(`AAC_OP_PASS_ON);
    expect_rsp(`AAC_OP_PASS_ON);
    s0 = n_starts;
    cmd2(8'h43);
    expect_rsp(8'h43);
    expect_rsp(`AAC_RSP_PLAY_GO);
    chk("play_cell", 8'h03, 8'(play_cell));
    chk("pass_through", 8'h00, 8'(pass_through));
    u_host.send(`AAC_OP_STATUS);
    expect_rsp(`AAC_OP_STATUS);
    expect_rsp({2'h1, spk});
    expect_rsp(8'h08);
    expect_rsp(8'h03);
    lfsr_q = lfsr_next(lfsr_q);
    r = 1 + int'(lfsr_q[1:0] % 2'h3);
    u_host.send(8'(r));
    expect_rsp(8'(r));
    repeat (r) pdone();
    chk("play_active", 8'h01, 8'(play_active));
    pdone();
    chk("play_active", 8'h00, 8'(play_active));
    chk("play_start count", 8'(r + 1), 8'(n_starts - s0));
    foreach (stop_op[i]) begin
      cmd2(8'h46);
      expect_rsp(8'h46);
      expect_rsp(`AAC_RSP_PLAY_GO);
      u_host.send(stop_op[i]);
      expect_rsp(stop_op[i]);
      chk("play_active", 8'h00, 8'(play_active));
    end
    audio_detect <= 1'b1;
    cmd2(8'h85);
    expect_rsp(8'h85);
    chk("rec_cell", 8'h05, 8'(rec_cell));
    audio_detect <= 1'b0;
    repeat (SIL_CYC - 8) @(posedge clk);
    chk("rec_active", 8'h01, 8'(rec_active));
    expect_rsp(`AAC_RSP_REC_DONE);
    chk("rec_active", 8'h00, 8'(rec_active));
    host_dtr <= 1'b0;
    repeat (4) @(posedge clk);
    b = {2'h3, ~spk};
    fr = {1'b1, b, 1'b0};
    fork
      u_host.send(b);
      for (int i = 0; i < 10; i++) begin
        repeat ((i == 0) ? BIT_CYC / 2 + 1 : BIT_CYC) @(posedge clk);
        chk("printer_txd", 8'(fr[i]), 8'(printer_txd));
      end
    join
    u_host.send(b);
    quiet(600);
    chk("speaker_on", 8'(spk), 8'(speaker_on));
    host_dtr <= 1'b1;
    button <= 1'b1;
    repeat (40) @(posedge clk);
    button <= 1'b0;
    repeat (8) @(posedge clk);
    chk("leds", 8'h0f, 8'(leds));
    for (int k = 1; k <= 2; k++) begin
      button <= 1'b1;
      repeat (4) @(posedge clk);
      button <= 1'b0;
      repeat (8) @(posedge clk);
      chk("leds", 8'(k), 8'(leds));
    end
    audio_detect <= 1'b1;
    repeat (6) @(posedge clk);
    chk("rec_cell", 8'h02, 8'(rec_cell));
    seen0 = 0;
    seen_sel = 0;
    repeat (30) begin
      @(posedge clk);
      if (leds === 4'h0) seen0 = 1;
      if (leds === 4'h2) seen_sel = 1;
    end
    chk("leds blink", 8'h01, 8'(seen0 & seen_sel));
    // Audio must be gone through the synchroniser first, or manual mode restarts recording
    audio_detect <= 1'b0;
    repeat (4) @(posedge clk);
    cell_full <= 1'b1;
    @(posedge clk);
    cell_full <= 1'b0;
    expect_rsp(`AAC_RSP_REC_DONE);
    chk("leds", 8'h02, 8'(leds));
    chk("rec_start count", 8'h02, 8'(n_rec));
    test_done();
  end
endmodule
